// ---- timer_pkg.sv ----
// constants shared by the timer channel, its prescaler and its bus slave
package timer_pkg;
  // byte address width on the register bus
  localparam int ADDR_W = 12;
  // register word indexes; the byte address is four times the index
  localparam logic [9:0] IDX_RUN = 10'h180;
  localparam logic [9:0] IDX_MODE = 10'h182;
  localparam logic [9:0] IDX_FLOP = 10'h183;
  localparam logic [9:0] IDX_CMP0L = 10'h188;
  localparam logic [9:0] IDX_CMP0H = 10'h189;
  localparam logic [9:0] IDX_CMP1L = 10'h18a;
  localparam logic [9:0] IDX_CMP1H = 10'h18b;
  localparam logic [9:0] IDX_CAP0L = 10'h18c;
  localparam logic [9:0] IDX_CAP0H = 10'h18d;
  localparam logic [9:0] IDX_CAP1L = 10'h18e;
  localparam logic [9:0] IDX_CAP1H = 10'h18f;
  localparam logic [9:0] IDX_STAT = 10'h1a0;
  localparam logic [9:0] IDX_CLR = 10'h1a1;
  localparam logic [9:0] IDX_IEN = 10'h1a2;
  localparam logic [9:0] IDX_CLK = 10'h1a3;
  // run_control fields
  localparam int RUN_CNT = 0;
  localparam int RUN_PRE = 2;
  localparam int RUN_DBUF = 7;
  localparam logic [7:0] RUN_WMASK = 8'h8d;
  // mode_control fields and reset value
  localparam int MOD_CKS = 0;
  localparam int MOD_CLE = 2;
  localparam int MOD_CPM = 3;
  localparam int MOD_SWCAP = 5;
  localparam logic [7:0] MOD_RST = 8'h20;
  localparam logic [7:0] MOD_WMASK = 8'h3f;
  // flop_control fields and action codes
  localparam int FFC0 = 0;
  localparam int FFEN = 2;
  localparam int FFC1 = 6;
  localparam logic [1:0] FF_INV = 2'h0;
  localparam logic [1:0] FF_SET = 2'h1;
  localparam logic [1:0] FF_CLR = 2'h2;
  // clock configuration fields
  localparam int CLK_GEAR = 0;
  localparam int CLK_PSS = 3;
  localparam int CLK_LF = 5;
  localparam logic [7:0] CLK_WMASK = 8'h3f;
  localparam logic [1:0] PSS_FC16 = 2'h2;
  // count clock and capture mode codes
  localparam logic [1:0] CKS_EXT = 2'h0;
  localparam logic [1:0] CKS_FAST = 2'h1;
  localparam logic [1:0] CKS_MED = 2'h2;
  localparam logic [1:0] CPM_RISE01 = 2'h1;
  localparam logic [1:0] CPM_EDGES0 = 2'h2;
  localparam logic [1:0] CPM_EDGES1 = 2'h3;
  // status bits
  localparam int ST_OVF = 0;
  localparam int ST_M0 = 1;
  localparam int ST_M1 = 2;
  localparam int ST_C0 = 3;
  localparam int ST_C1 = 4;
  localparam int ST_W = 5;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage // timer_pkg

// ---- timer_if.sv ----
// carriers between the timer channel, its prescaler and its bus slave
`timescale 1ns/100ps
interface tick_if;
  logic run; // prescaler runs while high
  logic use_lf; // low-frequency clock is the source
  logic lf_tick; // one pulse per low-frequency clock rise
  logic [2:0] gear; // clock gear divisor
  logic [1:0] src_sel; // prescaler source select
  logic tap_fast; // one-cycle tap pulses
  logic tap_medium;
  logic tap_slow;
  modport ctrl (output run, use_lf, lf_tick, gear, src_sel,
                input tap_fast, tap_medium, tap_slow);
  modport presc (input run, use_lf, lf_tick, gear, src_sel,
                 output tap_fast, tap_medium, tap_slow);
endinterface // tick_if

interface regacc_if;
  logic wr; // one-cycle byte write strobe
  logic rd; // one-cycle read strobe
  logic [9:0] widx; // word index of the write
  logic [9:0] ridx; // word index of the read
  logic [7:0] wdata;
  logic [7:0] rdata; // combinational read data
  logic werr; // write index unmapped
  logic rerr; // read index unmapped
  modport bus (output wr, rd, widx, ridx, wdata,
               input rdata, werr, rerr);
  modport regs (input wr, rd, widx, ridx, wdata,
                output rdata, werr, rerr);
endinterface // regacc_if

// ---- prescaler.sv ----
// five-bit prescaler with clock gear and source select
`timescale 1ns/100ps
module prescaler (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // settings in, taps out
  tick_if.presc t
);
  import timer_pkg::*;

  typedef struct packed {
    logic [3:0] div; // free divider of the high-frequency clock
    logic [1:0] quarter; // divide-by-four to the base clock
    logic [4:0] pre; // the prescaler proper
  } presc_st_t;

  presc_st_t st_reg;
  presc_st_t st_next;
  logic src_tick; // selected source clock enable
  logic base_tick; // prescaler base clock enable
  logic hf_g0; // helper: fastest high-frequency setting, running

  // one pulse every 2^gear cycles; codes above four act as four
  function automatic logic gear_tick(input logic [3:0] d,
                                     input logic [2:0] g);
    case (g)
      3'h0: gear_tick = 1'b1;
      3'h1: gear_tick = d[0];
      3'h2: gear_tick = &d[1:0];
      3'h3: gear_tick = &d[2:0];
      default: gear_tick = &d;
    endcase
  endfunction

  // next state: the gear divider runs free, the rest only while enabled
  always_comb begin
    st_next = st_reg;
    st_next.div = st_reg.div + 4'h1;
    if (t.use_lf) begin
      src_tick = t.lf_tick;
    end else if (t.src_sel == PSS_FC16) begin
      src_tick = &st_reg.div;
    end else begin
      src_tick = gear_tick(st_reg.div, t.gear);
    end
    base_tick = t.run && src_tick && (&st_reg.quarter);
    if (!t.run) begin
      st_next.quarter = 2'h0;
      st_next.pre = 5'h00;
    end else if (src_tick) begin
      st_next.quarter = st_reg.quarter + 2'h1;
      if (base_tick) begin
        st_next.pre = st_reg.pre + 5'h01;
      end
    end
  end

  // taps decode one counter, so they stay aligned and restart together
  assign t.tap_fast = base_tick && st_reg.pre[0];
  assign t.tap_medium = base_tick && (&st_reg.pre[2:0]);
  assign t.tap_slow = base_tick && (&st_reg.pre);

  // state register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hf_g0 = t.run && !t.use_lf && t.gear == 3'h0 && t.src_sel == 2'h0;

  a_fast_gap: assert property (@(posedge core_clk) disable iff (!arst_n)
    t.tap_fast |=> !t.tap_fast [*7])
    else $error("fast tap came too soon");
  a_gear0_period: assert property (@(posedge core_clk) disable iff (!arst_n)
    (t.tap_fast && hf_g0) ##1 hf_g0 [*8] |-> t.tap_fast)
    else $error("fast tap period not eight cycles");
  a_nested_taps: assert property (@(posedge core_clk) disable iff (!arst_n)
    (t.tap_slow |-> t.tap_medium) and (t.tap_medium |-> t.tap_fast))
    else $error("taps out of phase");
  a_restart_clean: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(t.run) |-> !t.tap_fast [*7])
    else $error("prescaler not cleared before restart");
endmodule // prescaler

// ---- axi_byte_slave.sv ----
// axi4-lite slave that turns word accesses into byte register strobes
`timescale 1ns/100ps
module axi_byte_slave (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // write address and data
  input wire logic [timer_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address and data
  input wire logic [timer_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register side
  regacc_if.bus r
);
  import timer_pkg::*;

  typedef struct packed {
    logic aw_full; // write address held
    logic [9:0] aw_idx;
    logic w_full; // write data held
    logic [7:0] wbyte;
    logic w_en; // low byte lane was strobed
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rbyte;
    logic [1:0] rresp;
  } bus_st_t;

  bus_st_t st_reg;
  bus_st_t st_next;
  logic do_wr; // both halves held and no response pending
  logic rd_take; // read address accepted this cycle

  // holding slots let address and data arrive in either order
  always_comb begin
    st_next = st_reg;
    do_wr = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;
    rd_take = arvalid && !st_reg.rvalid;
    if (awvalid && !st_reg.aw_full) begin
      st_next.aw_full = 1'b1;
      st_next.aw_idx = awaddr[ADDR_W-1:2];
    end
    if (wvalid && !st_reg.w_full) begin
      st_next.w_full = 1'b1;
      st_next.wbyte = wdata[7:0];
      st_next.w_en = wstrb[0];
    end
    if (do_wr) begin
      st_next.aw_full = 1'b0;
      st_next.w_full = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = r.werr ? RESP_SLVERR : RESP_OKAY;
    end else if (st_reg.bvalid && bready) begin
      st_next.bvalid = 1'b0;
    end
    if (rd_take) begin
      st_next.rvalid = 1'b1;
      st_next.rbyte = r.rdata;
      st_next.rresp = r.rerr ? RESP_SLVERR : RESP_OKAY;
    end else if (st_reg.rvalid && rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  // strobes toward the register file; a write without lane 0 only answers
  assign r.wr = do_wr && st_reg.w_en;
  assign r.widx = st_reg.aw_idx;
  assign r.wdata = st_reg.wbyte;
  assign r.rd = rd_take;
  assign r.ridx = araddr[ADDR_W-1:2];

  // bus outputs
  assign awready = !st_reg.aw_full;
  assign wready = !st_reg.w_full;
  assign bvalid = st_reg.bvalid;
  assign bresp = st_reg.bresp;
  assign arready = !st_reg.rvalid;
  assign rvalid = st_reg.rvalid;
  assign rresp = st_reg.rresp;
  assign rdata = {24'h000000, st_reg.rbyte};

  // state register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  a_bresp_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");
  a_write_done: assert property (@(posedge core_clk) disable iff (!arst_n)
    do_wr |=> bvalid && awready && wready)
    else $error("write did not complete in one cycle");
endmodule // axi_byte_slave

// ---- timer_channel.sv ----
// one channel of the sixteen-bit timer and event counter
`timescale 1ns/100ps
module timer_channel (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // axi4-lite write address and data
  input wire logic [timer_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [timer_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // pins
  input wire logic event_capture_input_0,
  input wire logic event_capture_input_1,
  input wire logic low_freq_clock,
  output logic flop_output_0,
  output logic flop_output_1,
  // interrupt
  output logic irq
);
  import timer_pkg::*;

  typedef struct packed {
    logic [2:0] in0_sync; // [0] first stage, [1] second, [2] previous
    logic [2:0] in1_sync;
    logic [2:0] lf_sync;
    logic [7:0] run_ctl;
    logic [7:0] mode_ctl;
    logic [3:0] flop_en; // invert on match0, match1, cap0, cap1; flop 1 only on match1, cap1
    logic [7:0] clk_cfg;
    logic [15:0] count; // the up counter
    logic [15:0] cmp0;
    logic [15:0] cmp0_buf; // register buffer behind compare 0
    logic [15:0] cmp1;
    logic [15:0] cap0;
    logic [15:0] cap1;
    logic ff0;
    logic ff1;
    logic [ST_W-1:0] status; // sticky events
    logic [ST_W-1:0] irq_en;
  } chan_st_t;

  chan_st_t st_reg;
  chan_st_t st_next;
  logic in0_rise; // synchronised pin edges
  logic in0_fall;
  logic in1_rise;
  logic in1_fall;
  logic cnt_on; // counter and prescaler both running
  logic tick_sel; // selected count clock
  logic tick; // count clock, gated by run
  logic match0;
  logic match1;
  logic clr_hit; // clear-on-match fires
  logic ovf;
  logic cap0_ev;
  logic cap1_ev;
  logic sw_cap; // software capture into capture 0
  logic cmp0_wr; // helper: software writes compare 0
  logic [ST_W-1:0] ev;
  logic [ST_W-1:0] clr;

  tick_if p ();
  regacc_if r ();

  // every mapped byte index, used to answer unmapped accesses
  function automatic logic mapped(input logic [9:0] idx);
    mapped = idx inside {IDX_RUN, IDX_MODE, IDX_FLOP, IDX_CMP0L,
                         IDX_CMP0H, IDX_CMP1L, IDX_CMP1H, IDX_CAP0L,
                         IDX_CAP0H, IDX_CAP1L, IDX_CAP1H, IDX_STAT,
                         IDX_CLR, IDX_IEN, IDX_CLK};
  endfunction

  // software action on a timer flop; code three leaves it alone
  function automatic logic ff_ctl(input logic cur, input logic [1:0] code);
    case (code)
      FF_INV: ff_ctl = !cur;
      FF_SET: ff_ctl = 1'b1;
      FF_CLR: ff_ctl = 1'b0;
      default: ff_ctl = cur;
    endcase
  endfunction

  // edges only from the second sync stage and its delayed copy
  assign in0_rise = st_reg.in0_sync[1] && !st_reg.in0_sync[2];
  assign in0_fall = !st_reg.in0_sync[1] && st_reg.in0_sync[2];
  assign in1_rise = st_reg.in1_sync[1] && !st_reg.in1_sync[2];
  assign in1_fall = !st_reg.in1_sync[1] && st_reg.in1_sync[2];
  assign cmp0_wr = r.wr && (r.widx == IDX_CMP0L || r.widx == IDX_CMP0H);

  // prescaler settings
  assign p.run = st_reg.run_ctl[RUN_PRE];
  assign p.use_lf = st_reg.clk_cfg[CLK_LF];
  assign p.gear = st_reg.clk_cfg[CLK_GEAR +: 3];
  assign p.src_sel = st_reg.clk_cfg[CLK_PSS +: 2];
  assign p.lf_tick = st_reg.lf_sync[1] && !st_reg.lf_sync[2];

  prescaler u_pre (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .t(p.presc)
  );

  axi_byte_slave u_bus (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .r(r.bus)
  );

  // next state of the whole channel
  always_comb begin
    st_next = st_reg;
    st_next.in0_sync = {st_reg.in0_sync[1:0], event_capture_input_0};
    st_next.in1_sync = {st_reg.in1_sync[1:0], event_capture_input_1};
    st_next.lf_sync = {st_reg.lf_sync[1:0], low_freq_clock};
    cnt_on = st_reg.run_ctl[RUN_CNT] && st_reg.run_ctl[RUN_PRE];
    // count clock: external events or one of the taps
    case (st_reg.mode_ctl[MOD_CKS +: 2])
      CKS_EXT: tick_sel = in0_rise;
      CKS_FAST: tick_sel = p.tap_fast;
      CKS_MED: tick_sel = p.tap_medium;
      default: tick_sel = p.tap_slow;
    endcase
    tick = tick_sel && cnt_on;
    // comparators look at the value held when the count clock arrives
    match0 = tick && (st_reg.count == st_reg.cmp0);
    match1 = tick && (st_reg.count == st_reg.cmp1);
    clr_hit = match1 && st_reg.mode_ctl[MOD_CLE];
    ovf = tick && (&st_reg.count) && !clr_hit;
    // up counter: stop and clear while its run bit is low
    if (!st_reg.run_ctl[RUN_CNT]) begin
      st_next.count = 16'h0000;
    end else if (clr_hit) begin
      st_next.count = 16'h0000;
    end else if (tick) begin
      st_next.count = st_reg.count + 16'h0001;
    end
    if (match1 && st_reg.run_ctl[RUN_DBUF]) begin
      st_next.cmp0 = st_reg.cmp0_buf;
    end
    // hardware capture triggers by mode
    case (st_reg.mode_ctl[MOD_CPM +: 2])
      CPM_RISE01: begin
        cap0_ev = in0_rise;
        cap1_ev = in1_rise;
      end
      CPM_EDGES0: begin
        cap0_ev = in0_rise;
        cap1_ev = in0_fall;
      end
      CPM_EDGES1: begin
        cap0_ev = in1_rise;
        cap1_ev = in1_fall;
      end
      default: begin
        cap0_ev = 1'b0;
        cap1_ev = 1'b0;
      end
    endcase
    // writing zero, or writing over a held zero, captures by software while the prescaler run bit is set
    sw_cap = r.wr && r.widx == IDX_MODE && st_reg.run_ctl[RUN_PRE] &&
             (!r.wdata[MOD_SWCAP] || !st_reg.mode_ctl[MOD_SWCAP]);
    if (cap0_ev || sw_cap) begin
      st_next.cap0 = st_reg.count;
    end
    if (cap1_ev) begin
      st_next.cap1 = st_reg.count;
    end
    // simultaneous enabled events invert a flop only once
    if ((match0 && st_reg.flop_en[0]) || (match1 && st_reg.flop_en[1]) ||
        (cap0_ev && st_reg.flop_en[2]) || (cap1_ev && st_reg.flop_en[3])) begin
      st_next.ff0 = !st_reg.ff0;
    end
    if ((match1 && st_reg.flop_en[1]) || (cap1_ev && st_reg.flop_en[3])) begin
      st_next.ff1 = !st_reg.ff1;
    end
    // register writes are applied on top of the hardware updates above
    clr = '0;
    if (r.wr) begin
      case (r.widx)
        IDX_RUN: st_next.run_ctl = r.wdata & RUN_WMASK;
        IDX_MODE: st_next.mode_ctl = r.wdata & MOD_WMASK;
        IDX_FLOP: begin
          st_next.flop_en = r.wdata[FFEN +: 4];
          st_next.ff0 = ff_ctl(st_next.ff0, r.wdata[FFC0 +: 2]);
          st_next.ff1 = ff_ctl(st_next.ff1, r.wdata[FFC1 +: 2]);
        end
        IDX_CMP0L: begin
          st_next.cmp0_buf[7:0] = r.wdata;
          if (!st_reg.run_ctl[RUN_DBUF]) begin
            st_next.cmp0[7:0] = r.wdata;
          end
        end
        IDX_CMP0H: begin
          st_next.cmp0_buf[15:8] = r.wdata;
          if (!st_reg.run_ctl[RUN_DBUF]) begin
            st_next.cmp0[15:8] = r.wdata;
          end
        end
        IDX_CMP1L: st_next.cmp1[7:0] = r.wdata;
        IDX_CMP1H: st_next.cmp1[15:8] = r.wdata;
        IDX_CLR: clr = r.wdata[ST_W-1:0];
        IDX_IEN: st_next.irq_en = r.wdata[ST_W-1:0];
        IDX_CLK: st_next.clk_cfg = r.wdata & CLK_WMASK;
        default: ; // read-only and unmapped writes change nothing
      endcase
    end
    // sticky events: a new event beats a clear in the same cycle
    ev = '0;
    ev[ST_OVF] = ovf;
    ev[ST_M0] = match0;
    ev[ST_M1] = match1;
    ev[ST_C0] = cap0_ev || sw_cap;
    ev[ST_C1] = cap1_ev;
    st_next.status = (st_reg.status & ~clr) | ev;
  end

  // read mux; flop action fields read as the no-change code
  always_comb begin
    case (r.ridx)
      IDX_RUN: r.rdata = st_reg.run_ctl;
      IDX_MODE: r.rdata = st_reg.mode_ctl;
      IDX_FLOP: r.rdata = {2'h3, st_reg.flop_en, 2'h3};
      IDX_CMP0L: r.rdata = st_reg.cmp0[7:0];
      IDX_CMP0H: r.rdata = st_reg.cmp0[15:8];
      IDX_CMP1L: r.rdata = st_reg.cmp1[7:0];
      IDX_CMP1H: r.rdata = st_reg.cmp1[15:8];
      IDX_CAP0L: r.rdata = st_reg.cap0[7:0];
      IDX_CAP0H: r.rdata = st_reg.cap0[15:8];
      IDX_CAP1L: r.rdata = st_reg.cap1[7:0];
      IDX_CAP1H: r.rdata = st_reg.cap1[15:8];
      IDX_STAT: r.rdata = 8'(st_reg.status);
      IDX_IEN: r.rdata = 8'(st_reg.irq_en);
      IDX_CLK: r.rdata = st_reg.clk_cfg;
      default: r.rdata = 8'h00;
    endcase
  end
  assign r.werr = !mapped(r.widx);
  assign r.rerr = !mapped(r.ridx);

  // pins and interrupt
  assign flop_output_0 = st_reg.ff0;
  assign flop_output_1 = st_reg.ff1;
  assign irq = |(st_reg.status & st_reg.irq_en);

  // all state is local, so a second channel is an independent copy
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      st_reg.mode_ctl <= MOD_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  a_clear_match: assert property (@(posedge core_clk) disable iff (!arst_n)
    clr_hit |=> st_reg.count == 16'h0000 && !ovf)
    else $error("counter not cleared on compare 1 match");
  a_count_step: assert property (@(posedge core_clk) disable iff (!arst_n)
    tick && !clr_hit && !(r.wr && r.widx == IDX_RUN) |=>
    st_reg.count == 16'($past(st_reg.count) + 16'h0001))
    else $error("counter did not step by one");
  a_overflow_flag: assert property (@(posedge core_clk) disable iff (!arst_n)
    ovf |=> st_reg.status[ST_OVF] && st_reg.count == 16'h0000)
    else $error("wrap did not flag overflow");
  a_dbuf_load: assert property (@(posedge core_clk) disable iff (!arst_n)
    match1 && st_reg.run_ctl[RUN_DBUF] && !cmp0_wr |=>
    st_reg.cmp0 == $past(st_reg.cmp0_buf))
    else $error("buffer not moved into compare 0");
  a_set_wins: assert property (@(posedge core_clk) disable iff (!arst_n)
    ev != '0 |=> (st_reg.status & $past(ev)) == $past(ev))
    else $error("event lost against clear");
endmodule // timer_channel

// ---- ext_pins.sv ----
// pin model: event inputs and a free-running low-frequency clock
`timescale 1ns/100ps
module ext_pins (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // pulse window from the bench
  input wire logic go,
  // pins
  output logic in0,
  output logic in1,
  output logic lf
);
  logic [1:0] div; // four-cycle phase, keeps each level >= 2 cycles
  // lf toggles every fourth cycle; in0 pulses only while go is high
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {div, in0, in1, lf} <= '0;
    end else begin
      div <= div + 2'h1;
      in1 <= in0;
      if (div == 2'h3) begin
        lf <= ~lf;
        in0 <= ~in0 & go;
      end
    end
  end
endmodule // ext_pins

// ---- timer_channel_tb.sv ----
// self-checking bench for the timer channel
`timescale 1ns/100ps
module timer_channel_tb;
  import timer_pkg::*;
  logic core_clk = 0, arst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, go = 0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = '0;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, irq, f0, f1, i0, i1, lf;
  logic [7:0] rv;
  int mismatches = 0, compares = 0, cycles = 0;
  // rows: register, value written, value read back
  logic [9:0] ri[6] = '{IDX_CMP1L, IDX_CMP1H, IDX_IEN, IDX_CAP0L,
    IDX_RUN, IDX_FLOP};
  logic [7:0] rw[6] = '{8'h5a, 8'ha5, 8'h1f, 8'h77, 8'h88, 8'h3c};
  logic [7:0] re[6] = '{8'h5a, 8'ha5, 8'h1f, 8'h00, 8'h88, 8'hff};
  // clock config, mode and tap counts seen in ~800 cycles; medium, slow last
  logic [7:0] cfg[9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h20, 8'h10,
    8'h00, 8'h00};
  logic [7:0] md[9] = '{8'h21, 8'h21, 8'h21, 8'h21, 8'h21, 8'h21, 8'h21,
    8'h22, 8'h23};
  int expv[9] = '{100, 50, 25, 12, 6, 12, 6, 25, 6};
  timer_channel DUT (.core_clk, .arst_n, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .event_capture_input_0(i0), .event_capture_input_1(i1),
    .low_freq_clock(lf), .flop_output_0(f0), .flop_output_1(f1), .irq);
  ext_pins PM (.core_clk, .arst_n, .go, .in0(i0), .in1(i1), .lf);
  initial forever #2.5 core_clk = ~core_clk;
  // hang guard, well above the length of the run
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches = mismatches + 1;
      final_report();
    end
  end
  task automatic final_report();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // range compare; lo == hi gives an exact match, x never passes
  task automatic chk(string n, logic [7:0] lo, hi, g);
    compares++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      mismatches++;
      $display("ERROR %s expected %0h..%0h seen %0h", n, lo, hi, g);
    end
  endtask
  // axi write: address and data offered together, each released on take
  task automatic wr(logic [9:0] i, logic [7:0] d);
    logic a, w;
    a = 0;
    w = 0;
    @(posedge core_clk);
    awaddr <= {i, 2'h0};
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(a && w)) begin
      @(posedge core_clk);
      if (awready === 1'b1) a = 1;
      if (wready === 1'b1) w = 1;
      awvalid <= ~a;
      wvalid <= ~w;
    end
    do @(posedge core_clk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  // axi read of one byte register
  task automatic rd(logic [9:0] i);
    @(posedge core_clk);
    araddr <= {i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    rv = rdata[7:0];
    resp = rresp;
    rready <= 1'b0;
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(IDX_MODE);
    chk("mode", MOD_RST, MOD_RST, rv);
    rd(IDX_RUN);
    chk("run", 0, 0, rv);
    chk("flops", 0, 0, {6'h0, f1, f0});
    foreach (ri[k]) begin
      wr(ri[k], rw[k]);
      rd(ri[k]);
      chk("row", re[k], re[k], rv);
    end
    chk("flops", 3, 3, {6'h0, f1, f0});
    // set flop 0, clear flop 1, no inversion enables
    wr(IDX_FLOP, 8'h81);
    chk("flop_act", 1, 1, {6'h0, f1, f0});
    // unmapped place: refused, reads zero
    wr(10'h3ff, 8'h55);
    chk("bresp", RESP_SLVERR, RESP_SLVERR, {6'h0, resp});
    rd(10'h3ff);
    chk("rdata", 0, 0, rv);
    chk("rresp", RESP_SLVERR, RESP_SLVERR, {6'h0, resp});
    // restart from zero, count the chosen tap, capture by software
    for (int g = 0; g < 9; g++) begin
      wr(IDX_RUN, 8'h00);
      wr(IDX_CLK, cfg[g]);
      wr(IDX_MODE, md[g]);
      wr(IDX_RUN, 8'h05);
      repeat (800) @(posedge core_clk);
      wr(IDX_MODE, md[g] ^ 8'h20);
      rd(IDX_CAP0L);
      chk("taps", 8'(expv[g] - 1), 8'(expv[g] + 1), rv);
    end
    // five external pulses counted, captured on both edges of input 0
    wr(IDX_RUN, 8'h00);
    wr(IDX_CLK, 8'h00);
    wr(IDX_MODE, 8'h30);
    wr(IDX_RUN, 8'h05);
    go <= 1'b1;
    repeat (40) @(posedge core_clk);
    go <= 1'b0;
    repeat (20) @(posedge core_clk);
    rd(IDX_CAP0L);
    chk("cap_rise", 4, 4, rv);
    rd(IDX_CAP1L);
    chk("cap_fall", 5, 5, rv);
    wr(IDX_MODE, 8'h00);
    rd(IDX_CAP0L);
    chk("events", 5, 5, rv);
    // clear on compare1 = 3, buffered compare0, match interrupt, mask, clear
    wr(IDX_RUN, 8'h00);
    wr(IDX_CLR, 8'h1f);
    wr(IDX_IEN, 8'h04);
    wr(IDX_CMP1L, 8'h03);
    wr(IDX_CMP1H, 8'h00);
    wr(IDX_CMP0L, 8'h11);
    wr(IDX_RUN, 8'h80);
    wr(IDX_CMP0L, 8'h22);
    rd(IDX_CMP0L);
    chk("cmp0", 8'h11, 8'h11, rv);
    wr(IDX_MODE, 8'h25);
    wr(IDX_RUN, 8'h85);
    repeat (100) @(posedge core_clk);
    chk("irq", 1, 1, {7'h0, irq});
    rd(IDX_CMP0L);
    chk("cmp0", 8'h22, 8'h22, rv);
    wr(IDX_MODE, 8'h05);
    rd(IDX_CAP0L);
    chk("wrap", 0, 3, rv);
    wr(IDX_RUN, 8'h00);
    wr(IDX_IEN, 8'h00);
    chk("mask", 0, 0, {7'h0, irq});
    wr(IDX_IEN, 8'h04);
    chk("unmask", 1, 1, {7'h0, irq});
    wr(IDX_CLR, 8'h04);
    chk("clear", 0, 0, {7'h0, irq});
    // reset in mid-run brings back the reset values
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(IDX_IEN);
    chk("ien", 0, 0, rv);
    rd(IDX_MODE);
    chk("mode", MOD_RST, MOD_RST, rv);
    chk("flops", 0, 0, {6'h0, f1, f0});
    final_report();
  end
endmodule // timer_channel_tb
